// ### hdl/vcf_ctrl.sv
// Notes on behaviour
// [R1] each field answered by id then status
// [R2] field 0x49 waits microseconds before next field
// [R3] field 0x4a waits nanoseconds before next field
// [R4] field 0x4e loads stop and resume levels
// [R5] buffer holds bytes, free space counted
// [R6] ready output is active low
// [R7] free below stop level drives ready high
// [R8] free above resume level drives low
// [R9] reset levels are 20 and 40
// [R10] host stops sending while ready high
// [R11] ready generated for any packet interface
// [R12] gain field: input then output, within 90
// [R13] input samples scaled before encoding
// [R14] decoded samples scaled after decoding
// [R15] gain only for linear samples, packet mode
// [R16] host keeps gains at 0 dB normally
// [R17] each speech packet yields channel packet
// [R18] speech packets only in packet mode
// [R19] field 0x48 sets codec skip count
// [R20] gains signed whole dB, samples saturate
// [R21] multi-byte counts arrive high byte first
//
// Implementation choices: the register offsets and the APB interface to the registers.
module vcf_ctrl #(
	parameter int DEPTH = 256 // receive buffer bytes
) (
	input  wire logic        SYS_CLK,         // 40 MHz core clock
	input  wire logic        RST,             // synchronous, active high
	input  wire logic        PSEL,            // apb select
	input  wire logic        PENABLE,         // apb access phase
	input  wire logic        PWRITE,          // apb direction
	input  wire logic [7:0]  PADDR,           // apb byte address
	input  wire logic [31:0] PWDATA,          // apb write data
	output logic      [31:0] PRDATA,          // apb read data
	output logic             PREADY,          // apb ready
	output logic             PSLVERR,         // apb unmapped address
	input  wire logic [7:0]  RX_DATA,         // packet byte from framer
	input  wire logic        RX_FIRST,        // byte is a packet type
	input  wire logic        RX_WR,           // byte strobe
	output logic             RX_FLOW_READY_N, // low: send more
	output logic [7:0]       RESP_DATA,       // response byte
	output logic             RESP_VALID,      // response byte strobe
	output logic             CHAN_PKT,        // start one channel packet
	output logic [15:0]      CODEC_SKIP,      // codec samples to drop
	input  wire logic [15:0] ENC_IN,          // sample toward encoder
	input  wire logic        ENC_IN_VALID,    // its strobe
	output logic [15:0]      ENC_OUT,         // scaled encoder sample
	output logic             ENC_OUT_VALID,   // its strobe
	input  wire logic [15:0] DEC_IN,          // decoded sample
	input  wire logic        DEC_IN_VALID,    // its strobe
	output logic [15:0]      DEC_OUT,         // scaled decoded sample
	output logic             DEC_OUT_VALID    // its strobe
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 4 || DEPTH > 32768 || (1 << AW) != DEPTH)
			$error("DEPTH must be a power of two from 4 to 32768");
	end

	// receive buffer state
	logic [8:0]    mem [DEPTH];  // {type flag, byte}
	logic [AW-1:0] wr_ptr;       // write slot
	logic [AW-1:0] rd_ptr;       // head slot
	logic [AW:0]   fill;         // bytes held
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0]   next_fill;
	logic          push;         // accepted byte
	logic          pop;          // parser took head
	logic [15:0]   free_bytes;   // free space
	logic [8:0]    head;         // oldest byte

	// parser state
	vcf_pkg::vcf_state_t state;
	vcf_pkg::vcf_state_t next_state;
	logic [7:0]    field_id;
	logic [7:0]    next_field_id;
	logic [31:0]   arg;          // argument bytes, high byte first
	logic [31:0]   next_arg;
	logic [2:0]    arg_left;
	logic [2:0]    next_arg_left;
	logic          in_ctrl;      // inside a control packet
	logic          next_in_ctrl;
	logic [7:0]    status;
	logic [7:0]    next_status;
	logic [31:0]   delay_ns;     // pending wait
	logic [31:0]   next_delay_ns;
	logic [15:0]   stop_level;
	logic [15:0]   next_stop_level;
	logic [15:0]   resume_level;
	logic [15:0]   next_resume_level;
	logic [7:0]    in_gain;
	logic [7:0]    next_in_gain;
	logic [7:0]    out_gain;
	logic [7:0]    next_out_gain;
	logic [15:0]   next_skip;
	logic [7:0]    next_resp_data;
	logic          next_resp_valid;
	logic          next_chan;

	// flow, bus and sample state
	logic          next_ready_n;
	logic [1:0]    ctrl;         // {linear16, packet mode}
	logic [1:0]    next_ctrl;
	logic          next_pready;
	logic          next_pslverr;
	logic [31:0]   next_prdata;
	logic          gain_on;
	logic [15:0]   next_enc_out;
	logic [15:0]   next_dec_out;

	// gain as signed dB, about 6 dB per bit of shift, saturating
	function automatic logic [15:0] scale(input logic [15:0] x, input logic [7:0] g);
		logic signed [7:0]  sh;
		logic signed [31:0] w;
		sh = $signed(g) / vcf_pkg::DB_PER_BIT; // [R20]
		w = 32'($signed(x));
		if (sh >= 0)
			w = w <<< sh; // [R13] [R14]
		else
			w = w >>> (-sh);
		if (w > 32'sd32767)
			scale = 16'h7fff; // [R20]
		else if (w < -32'sd32768)
			scale = 16'h8000;
		else
			scale = w[15:0];
	endfunction

	// buffer pointers; a byte arriving when full is dropped
	always_comb begin
		head = mem[rd_ptr];
		push = RX_WR && (fill != (AW+1)'(DEPTH)); // [R10]
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_fill = fill + (AW+1)'(push) - (AW+1)'(pop); // [R5]
		free_bytes = 16'((AW+1)'(DEPTH) - fill); // [R5]
	end

	always_ff @(posedge SYS_CLK) begin
		if (push)
			mem[wr_ptr] <= {RX_FIRST, RX_DATA};
		if (RST) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill <= next_fill;
		end
	end

	// ready with hysteresis, independent of the packet interface
	always_comb begin
		next_ready_n = RX_FLOW_READY_N; // between levels: hold
		if (free_bytes < stop_level)
			next_ready_n = 1'b1; // [R7] [R6] [R11]
		else if (free_bytes > resume_level)
			next_ready_n = 1'b0; // [R8]
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST)
			RX_FLOW_READY_N <= 1'b0; // empty buffer: ready
		else
			RX_FLOW_READY_N <= next_ready_n;
	end

	// field parser; a type byte mid-field ends it with an error
	always_comb begin
		next_state = state;
		next_field_id = field_id;
		next_arg = arg;
		next_arg_left = arg_left;
		next_in_ctrl = in_ctrl;
		next_status = status;
		next_delay_ns = delay_ns;
		next_stop_level = stop_level;
		next_resume_level = resume_level;
		next_in_gain = in_gain;
		next_out_gain = out_gain;
		next_skip = CODEC_SKIP;
		next_resp_data = RESP_DATA;
		next_resp_valid = 1'b0;
		next_chan = 1'b0;
		pop = 1'b0;
		unique case (state)
			vcf_pkg::VCF_FIELD: begin
				if (fill != '0) begin
					pop = 1'b1;
					if (head[8]) begin
						next_in_ctrl = head[7:0] == vcf_pkg::PTYPE_CTRL;
						// speech outside packet mode is ignored
						next_chan = head[7:0] == vcf_pkg::PTYPE_SPEECH
							&& ctrl[vcf_pkg::CTRL_PKT_MODE]; // [R17] [R18]
					end else if (in_ctrl) begin
						next_field_id = head[7:0];
						next_arg = '0;
						next_status = vcf_pkg::STAT_OK;
						next_state = vcf_pkg::VCF_ARG;
						unique case (head[7:0])
							vcf_pkg::codec_skip_count_cmd,
							vcf_pkg::wait_micro_cmd,
							vcf_pkg::wait_nano_cmd,
							vcf_pkg::speech_gain_cmd: next_arg_left = vcf_pkg::ARGS_TWO;
							vcf_pkg::flow_threshold_cmd: next_arg_left = vcf_pkg::ARGS_FOUR;
							default: begin // unknown length: drop rest of packet
								next_status = vcf_pkg::STAT_ERR;
								next_in_ctrl = 1'b0;
								next_state = vcf_pkg::VCF_RID;
							end
						endcase
					end
				end
			end
			vcf_pkg::VCF_ARG: begin
				if (fill != '0) begin
					if (head[8]) begin // truncated field
						next_status = vcf_pkg::STAT_ERR;
						next_state = vcf_pkg::VCF_RID;
					end else begin
						pop = 1'b1;
						next_arg = {arg[23:0], head[7:0]}; // [R21]
						next_arg_left = arg_left - 1'b1;
						if (arg_left == 3'h1)
							next_state = vcf_pkg::VCF_APPLY;
					end
				end
			end
			vcf_pkg::VCF_APPLY: begin
				next_state = vcf_pkg::VCF_RID;
				unique case (field_id)
					vcf_pkg::codec_skip_count_cmd: next_skip = arg[15:0]; // [R19]
					vcf_pkg::wait_micro_cmd: next_delay_ns = 32'(arg[15:0]) * vcf_pkg::US_NS; // [R2]
					vcf_pkg::wait_nano_cmd: next_delay_ns = 32'(arg[15:0]); // [R3]
					vcf_pkg::flow_threshold_cmd: begin
						next_stop_level = arg[31:16]; // [R4]
						next_resume_level = arg[15:0];
					end
					default: begin // gain: refuse values beyond 90 dB
						if ($signed(arg[15:8]) > vcf_pkg::GAIN_MAX
							|| $signed(arg[15:8]) < vcf_pkg::GAIN_MIN
							|| $signed(arg[7:0]) > vcf_pkg::GAIN_MAX
							|| $signed(arg[7:0]) < vcf_pkg::GAIN_MIN)
							next_status = vcf_pkg::STAT_ERR;
						else begin
							next_in_gain = arg[15:8]; // [R12]
							next_out_gain = arg[7:0];
						end
					end
				endcase
			end
			vcf_pkg::VCF_RID: begin
				next_resp_valid = 1'b1; // [R1]
				next_resp_data = field_id;
				next_state = vcf_pkg::VCF_RSTAT;
			end
			vcf_pkg::VCF_RSTAT: begin
				next_resp_valid = 1'b1; // [R1]
				next_resp_data = status;
				next_state = (delay_ns != '0) ? vcf_pkg::VCF_WAIT : vcf_pkg::VCF_FIELD;
			end
			vcf_pkg::VCF_WAIT: begin
				// counting down in ns rounds a wait up to whole cycles
				if (delay_ns > vcf_pkg::STEP_NS)
					next_delay_ns = delay_ns - vcf_pkg::STEP_NS; // [R2] [R3]
				else begin
					next_delay_ns = '0;
					next_state = vcf_pkg::VCF_FIELD;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state <= vcf_pkg::VCF_FIELD;
			field_id <= '0;
			arg <= '0;
			arg_left <= '0;
			in_ctrl <= 1'b0;
			status <= vcf_pkg::STAT_OK;
			delay_ns <= '0;
			stop_level <= vcf_pkg::STOP_LEVEL_RST; // [R9]
			resume_level <= vcf_pkg::RESUME_LEVEL_RST;
			in_gain <= vcf_pkg::GAIN_RST;
			out_gain <= vcf_pkg::GAIN_RST;
			CODEC_SKIP <= vcf_pkg::SKIP_RST;
			RESP_DATA <= '0;
			RESP_VALID <= 1'b0;
			CHAN_PKT <= 1'b0;
		end else begin
			state <= next_state;
			field_id <= next_field_id;
			arg <= next_arg;
			arg_left <= next_arg_left;
			in_ctrl <= next_in_ctrl;
			status <= next_status;
			delay_ns <= next_delay_ns;
			stop_level <= next_stop_level;
			resume_level <= next_resume_level;
			in_gain <= next_in_gain;
			out_gain <= next_out_gain;
			CODEC_SKIP <= next_skip;
			RESP_DATA <= next_resp_data;
			RESP_VALID <= next_resp_valid;
			CHAN_PKT <= next_chan;
		end
	end

	// sample scaling, bypassed unless linear samples in packet mode
	always_comb begin
		gain_on = ctrl[vcf_pkg::CTRL_PKT_MODE] && ctrl[vcf_pkg::CTRL_LINEAR16]; // [R15]
		next_enc_out = gain_on ? scale(ENC_IN, in_gain) : ENC_IN; // [R13]
		next_dec_out = gain_on ? scale(DEC_IN, out_gain) : DEC_IN; // [R14]
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ENC_OUT <= '0;
			ENC_OUT_VALID <= 1'b0;
			DEC_OUT <= '0;
			DEC_OUT_VALID <= 1'b0;
		end else begin
			ENC_OUT <= next_enc_out;
			ENC_OUT_VALID <= ENC_IN_VALID;
			DEC_OUT <= next_dec_out;
			DEC_OUT_VALID <= DEC_IN_VALID;
		end
	end

	// apb slave: one wait-free access, read data latched in setup, ctrl write taken in access
	always_comb begin
		next_pready = PSEL && !PENABLE;
		next_pslverr = 1'b0;
		next_prdata = '0;
		next_ctrl = ctrl;
		unique case (PADDR)
			vcf_pkg::OFF_CTRL:   next_prdata = 32'(ctrl);
			vcf_pkg::OFF_LEVELS: next_prdata = {resume_level, stop_level};
			vcf_pkg::OFF_GAIN:   next_prdata = {16'h0000, out_gain, in_gain};
			vcf_pkg::OFF_STATUS: next_prdata = {15'h0000, RX_FLOW_READY_N, free_bytes};
			vcf_pkg::OFF_SKIP:   next_prdata = {16'h0000, CODEC_SKIP};
			default:             next_pslverr = PSEL && !PENABLE;
		endcase
		if (PSEL && PENABLE && PREADY && PWRITE && PADDR == vcf_pkg::OFF_CTRL)
			next_ctrl = PWDATA[1:0];
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= '0;
			ctrl <= 2'h0;
		end else begin
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
			PRDATA <= next_prdata;
			ctrl <= next_ctrl;
		end
	end

	// checks
	sequence id_then_status;
		RESP_VALID && RESP_DATA == $past(field_id) ##1 RESP_VALID && RESP_DATA == $past(status, 2);
	endsequence
	AST_RESP_PAIR: assert property (@(posedge SYS_CLK) disable iff (RST) // [R1]
		state == vcf_pkg::VCF_RID |=> id_then_status)
		else $error("response pair missing");
	AST_US_LOAD: assert property (@(posedge SYS_CLK) disable iff (RST) // [R2]
		state == vcf_pkg::VCF_APPLY && field_id == vcf_pkg::wait_micro_cmd
		|=> delay_ns == 32'($past(arg[15:0])) * 32'd1000)
		else $error("microsecond wait wrong");
	AST_NS_WAIT: assert property (@(posedge SYS_CLK) disable iff (RST) // [R3]
		state == vcf_pkg::VCF_WAIT && delay_ns > 32'd50
		|=> state == vcf_pkg::VCF_WAIT ##1 state == vcf_pkg::VCF_WAIT)
		else $error("wait ended early");
	AST_LEVEL_LOAD: assert property (@(posedge SYS_CLK) disable iff (RST) // [R4]
		state == vcf_pkg::VCF_APPLY && field_id == vcf_pkg::flow_threshold_cmd
		|=> stop_level == $past(arg[31:16]) && resume_level == $past(arg[15:0]))
		else $error("levels not loaded");
	AST_FREE: assert property (@(posedge SYS_CLK) disable iff (RST) // [R5]
		32'(free_bytes) + 32'(fill) == DEPTH)
		else $error("free count wrong");
	AST_STOP: assert property (@(posedge SYS_CLK) disable iff (RST) // [R7]
		free_bytes < stop_level |=> RX_FLOW_READY_N)
		else $error("ready not withdrawn");
	AST_GO: assert property (@(posedge SYS_CLK) disable iff (RST) // [R8]
		free_bytes > resume_level && free_bytes >= stop_level |=> !RX_FLOW_READY_N)
		else $error("ready not given");
	AST_LEVEL_RST: assert property (@(posedge SYS_CLK) // [R9]
		RST |=> stop_level == 16'h0014 && resume_level == 16'h0028)
		else $error("reset levels wrong");
	AST_BYPASS: assert property (@(posedge SYS_CLK) disable iff (RST) // [R15]
		!gain_on |=> ENC_OUT == $past(ENC_IN) && DEC_OUT == $past(DEC_IN))
		else $error("gain applied outside linear packet mode");
	AST_CHAN: assert property (@(posedge SYS_CLK) disable iff (RST) // [R17]
		pop && head == {1'b1, vcf_pkg::PTYPE_SPEECH} && ctrl[0] |=> CHAN_PKT)
		else $error("channel packet missing");
endmodule // vcf_ctrl

// ### include/vcf_pkg.sv
package vcf_pkg;
	// packet type codes
	localparam logic [7:0] PTYPE_CTRL   = 8'h00;
	localparam logic [7:0] PTYPE_CHAN   = 8'h01; // answer to a speech packet
	localparam logic [7:0] PTYPE_SPEECH = 8'h02;
	// control field identifiers
	localparam logic [7:0] codec_skip_count_cmd = 8'h48;
	localparam logic [7:0] wait_micro_cmd       = 8'h49;
	localparam logic [7:0] wait_nano_cmd        = 8'h4a;
	localparam logic [7:0] speech_gain_cmd      = 8'h4b;
	localparam logic [7:0] flow_threshold_cmd   = 8'h4e;
	// argument byte counts per field
	localparam logic [2:0] ARGS_TWO  = 3'h2;
	localparam logic [2:0] ARGS_FOUR = 3'h4;
	// response status bytes
	localparam logic [7:0] STAT_OK  = 8'h00;
	localparam logic [7:0] STAT_ERR = 8'h01;
	// reset values
	localparam logic [15:0] STOP_LEVEL_RST   = 16'h0014; // 20 bytes
	localparam logic [15:0] RESUME_LEVEL_RST = 16'h0028; // 40 bytes
	localparam logic [15:0] SKIP_RST         = 16'h0000;
	localparam logic [7:0]  GAIN_RST         = 8'h00;    // 0 dB
	// gain limits and shift step
	localparam logic signed [7:0] GAIN_MAX   = 8'sd90;
	localparam logic signed [7:0] GAIN_MIN   = -8'sd90;
	localparam logic signed [7:0] DB_PER_BIT = 8'sd6;
	// timing
	localparam int CLK_PERIOD_NS = 25;   // 40 MHz core clock
	localparam int NS_PER_US     = 1000;
	localparam logic [31:0] STEP_NS = 32'(CLK_PERIOD_NS);
	localparam logic [31:0] US_NS   = 32'(NS_PER_US);
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_LEVELS = 8'h04;
	localparam logic [7:0] OFF_GAIN   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_SKIP   = 8'h10;
	// control and status register fields
	localparam int CTRL_PKT_MODE = 0;
	localparam int CTRL_LINEAR16 = 1;
	localparam int STAT_READY_N  = 16;
	// parser states, gray from VCF_FIELD through VCF_WAIT
	typedef enum logic [2:0] {
		VCF_FIELD = 3'b000,
		VCF_ARG   = 3'b001,
		VCF_APPLY = 3'b011,
		VCF_RID   = 3'b010,
		VCF_RSTAT = 3'b110,
		VCF_WAIT  = 3'b111
	} vcf_state_t;
endpackage

// ### test/vcf_host.sv
// host side: feeds packet bytes and records response bytes
module vcf_host (
	input  wire logic       clk,        // core clock
	input  wire logic       ready_n,    // flow control, low asks for more
	input  wire logic [7:0] resp_data,  // response byte
	input  wire logic       resp_valid, // response strobe
	output logic      [7:0] tx_data,    // packet byte
	output logic            tx_first,   // byte starts a packet
	output logic            tx_wr       // byte strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] txq[$]; // pending bytes, top bit marks a type byte
	logic [7:0] rq[$];  // responses seen, in order
	int         rt[$];  // cycle of each response byte
	int         cyc;    // free-running cycle count

	initial begin
		tx_data = 8'h00;
		tx_first = 1'b0;
		tx_wr = 1'b0;
		cyc = 0;
	end

	// queue one byte for sending
	task automatic push(input logic first, input logic [7:0] b);
		txq.push_back({first, b});
	endtask

	// one byte a cycle while the device asks for more
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (resp_valid === 1'b1) begin // capture each response byte
			rq.push_back(resp_data);
			rt.push_back(cyc);
		end
		if (txq.size() > 0 && ready_n === 1'b0) begin
			{tx_first, tx_data} <= txq.pop_front();
			tx_wr <= 1'b1;
		end else begin // idle lines toggle, so no stale byte looks valid
			tx_data <= ~tx_data;
			tx_first <= ~tx_first;
			tx_wr <= 1'b0;
		end
	end
endmodule // vcf_host

// ### test/vcf_ctrl_tb.sv
module vcf_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 64; // small buffer so it fills quickly
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, rx_data, resp_data;
	logic [31:0] pwdata, prdata;
	logic        rx_first, rx_wr, ready_n, resp_valid, chan_pkt;
	logic [15:0] codec_skip, enc_in, enc_out, dec_in, dec_out;
	logic        enc_v, enc_ov, dec_v, dec_ov;
	int          num_errors, cmp_count; // mismatches and comparisons

	vcf_ctrl #(.DEPTH(DEPTH)) vcf_ctrl_i (.SYS_CLK(clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_DATA(rx_data),
		.RX_FIRST(rx_first), .RX_WR(rx_wr), .RX_FLOW_READY_N(ready_n),
		.RESP_DATA(resp_data), .RESP_VALID(resp_valid), .CHAN_PKT(chan_pkt),
		.CODEC_SKIP(codec_skip), .ENC_IN(enc_in), .ENC_IN_VALID(enc_v),
		.ENC_OUT(enc_out), .ENC_OUT_VALID(enc_ov), .DEC_IN(dec_in),
		.DEC_IN_VALID(dec_v), .DEC_OUT(dec_out), .DEC_OUT_VALID(dec_ov));
	vcf_host vcf_host_i (.clk(clk), .ready_n(ready_n), .resp_data(resp_data),
		.resp_valid(resp_valid), .tx_data(rx_data), .tx_first(rx_first), .tx_wr(rx_wr));

	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic tmo(input string nm);
		num_errors++;
		$display("wrong value %s expected done seen timeout", nm);
		print_verdict();
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) tmo("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// read and compare one register
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic        e;
		apb(1'b0, a, 32'h0, d, e);
		chk($sformatf("reg %h", a), exp, d);
		chk("slverr", 32'h0, {31'h0, e});
	endtask

	task automatic wrc(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] d;
		logic        e;
		apb(1'b1, a, v, d, e);
		chk("write slverr", 32'h0, {31'h0, e});
	endtask

	// one control packet: type byte then field bytes
	task automatic pkt(input logic [7:0] b[$]);
		vcf_host_i.push(1'b1, vcf_pkg::PTYPE_CTRL);
		foreach (b[i]) vcf_host_i.push(1'b0, b[i]);
	endtask

	// next two response bytes; t gets the cycle of the id byte
	task automatic resp(input logic [7:0] id, input logic [7:0] st, output int t);
		int n;
		for (n = 0; n < 3000 && vcf_host_i.rq.size() < 2; n++) @(posedge clk);
		if (n >= 3000) tmo("response");
		t = vcf_host_i.rt.pop_front();
		void'(vcf_host_i.rt.pop_front());
		chk("resp id", {24'h0, id}, {24'h0, vcf_host_i.rq.pop_front()});
		chk("resp status", {24'h0, st}, {24'h0, vcf_host_i.rq.pop_front()});
	endtask

	// let the host queue drain, then settle
	task automatic drain();
		int n;
		for (n = 0; n < 500 && vcf_host_i.txq.size() > 0; n++) @(posedge clk);
		if (n >= 500) tmo("drain");
		repeat (4) @(posedge clk);
	endtask

	task automatic samp(input logic [15:0] ei, di, eo, dx);
		@(posedge clk);
		enc_in <= ei;
		dec_in <= di;
		enc_v <= 1'b1;
		dec_v <= 1'b1;
		@(posedge clk);
		enc_v <= 1'b0;
		dec_v <= 1'b0;
		@(negedge clk);
		chk("enc out", {15'h0, 1'b1, eo}, {15'h0, enc_ov, enc_out});
		chk("dec out", {15'h0, 1'b1, dx}, {15'h0, dec_ov, dec_out});
	endtask

	task automatic chan_count(output int c);
		c = 0;
		repeat (20) @(negedge clk) if (chan_pkt === 1'b1) c++;
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic        e;
		rdc(vcf_pkg::OFF_LEVELS, 32'h0028_0014);
		wrc(vcf_pkg::OFF_LEVELS, 32'hffff_ffff);
		rdc(vcf_pkg::OFF_LEVELS, 32'h0028_0014);
		rdc(vcf_pkg::OFF_GAIN, 32'h0);
		rdc(vcf_pkg::OFF_SKIP, 32'h0);
		rdc(vcf_pkg::OFF_STATUS, 32'(DEPTH));
		apb(1'b0, 8'h40, 32'h0, d, e);
		chk("unmapped slverr", 32'h1, {31'h0, e});
		$display("test reset done");
	endtask

	task automatic t_delay();
		int t0, t1, t2, t3;
		pkt('{8'h49, 8'h00, 8'h01, 8'h48, 8'h00, 8'h00, 8'h4a, 8'h01, 8'hf4, 8'h48, 8'h00, 8'h00});
		resp(8'h49, 8'h00, t0);
		resp(8'h48, 8'h00, t1);
		resp(8'h4a, 8'h00, t2);
		resp(8'h48, 8'h00, t3);
		chk("us gap", 32'h1, {31'h0, t1 - t0 - 1 >= 41 && t1 - t0 - 1 <= 52});
		chk("ns gap", 32'h1, {31'h0, t3 - t2 - 1 >= 21 && t3 - t2 - 1 <= 32});
		$display("test delay done");
	endtask

	task automatic t_flow();
		int t, n;
		pkt('{8'h49, 8'h00, 8'h0a}); // stall the parser for 400 cycles
		resp(8'h49, 8'h00, t);
		for (n = 0; n < 44; n++) vcf_host_i.push(1'b0, (n % 3 == 0) ? 8'h48 : 8'h00);
		drain();
		chk("ready at stop level", 32'h0, {31'h0, ready_n});
		vcf_host_i.push(1'b0, 8'h00);
		drain();
		chk("ready below stop", 32'h1, {31'h0, ready_n});
		rdc(vcf_pkg::OFF_STATUS, 32'h0001_0013);
		pkt('{8'h48, 8'h00});
		void'(vcf_host_i.txq.pop_front());
		vcf_host_i.push(1'b0, 8'h00);
		repeat (10) @(posedge clk);
		chk("bytes held", 32'h3, 32'(vcf_host_i.txq.size()));
		rdc(vcf_pkg::OFF_STATUS, 32'h0001_0013);
		for (n = 0; n < 1000 && ready_n !== 1'b0; n++) @(posedge clk);
		if (n >= 1000) tmo("ready low");
		for (n = 0; n < 16; n++) resp(8'h48, 8'h00, t);
		drain();
		rdc(vcf_pkg::OFF_STATUS, 32'(DEPTH));
		$display("test flow done");
	endtask

	task automatic t_fields();
		int t;
		pkt('{8'h48, 8'h01, 8'h23, 8'h4e, 8'h00, 8'h1e, 8'h00, 8'h50,
			8'h4b, 8'h0c, 8'hf4, 8'h4b, 8'h5b, 8'h00});
		resp(8'h48, 8'h00, t);
		resp(8'h4e, 8'h00, t);
		resp(8'h4b, 8'h00, t);
		resp(8'h4b, 8'h01, t);
		rdc(vcf_pkg::OFF_SKIP, 32'h0123);
		chk("codec skip", 32'h0123, {16'h0, codec_skip});
		rdc(vcf_pkg::OFF_LEVELS, 32'h0050_001e);
		rdc(vcf_pkg::OFF_GAIN, 32'hf40c);
		pkt('{8'h37, 8'h48, 8'h00, 8'h00}); // unknown id drops the rest
		pkt('{8'h48, 8'h00}); // cut short by the next type byte
		pkt('{8'h49, 8'h00, 8'h00});
		resp(8'h37, 8'h01, t);
		resp(8'h48, 8'h01, t);
		resp(8'h49, 8'h00, t);
		rdc(vcf_pkg::OFF_SKIP, 32'h0123);
		$display("test fields done");
	endtask

	task automatic t_gain();
		int t;
		wrc(vcf_pkg::OFF_CTRL, 32'h3);
		samp(16'h0100, 16'hfc00, 16'h0400, 16'hff00);
		samp(16'h4000, 16'h0400, 16'h7fff, 16'h0100);
		samp(16'hc000, 16'h0004, 16'h8000, 16'h0001);
		wrc(vcf_pkg::OFF_CTRL, 32'h1);
		samp(16'h0100, 16'hfc00, 16'h0100, 16'hfc00);
		pkt('{8'h4b, 8'h00, 8'h00}); // back to 0 dB for normal use
		resp(8'h4b, 8'h00, t);
		rdc(vcf_pkg::OFF_GAIN, 32'h0);
		$display("test gain done");
	endtask

	task automatic t_speech();
		int c;
		vcf_host_i.push(1'b1, vcf_pkg::PTYPE_SPEECH);
		chan_count(c);
		chk("chan in packet mode", 32'h1, 32'(c));
		wrc(vcf_pkg::OFF_CTRL, 32'h0);
		vcf_host_i.push(1'b1, vcf_pkg::PTYPE_SPEECH);
		chan_count(c);
		chk("chan outside packet mode", 32'h0, 32'(c));
		$display("test speech done");
	endtask

	// reset in mid-run puts levels and skip count back
	task automatic t_rerst();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(vcf_pkg::OFF_LEVELS, 32'h0028_0014);
		rdc(vcf_pkg::OFF_SKIP, 32'h0);
		rdc(vcf_pkg::OFF_STATUS, 32'(DEPTH));
		$display("test mid-run reset done");
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, enc_v, dec_v} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		enc_in = 16'h0;
		dec_in = 16'h0;
		num_errors = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_delay();
		t_flow();
		t_fields();
		t_gain();
		t_speech();
		t_rerst();
		print_verdict();
	end
endmodule // vcf_ctrl_tb
